// ==== hw/fsp_ctrl.sv ====
/*
  Flash self-programming controller: timed store/load commands over APB,
  fuse, lock and signature read-back, page erase/write sequencing and
  boot section decode.
  Assumes: fuse and lock pins are asynchronous and static; flash_rdata
  is combinational from nvm_addr on pclk; por_n only falls at power-up.
*/
// Behaviour
// - Timed load at pointer 3 in lock mode returns high fuse byte.
// - Pointer 2 in lock mode returns extended fuse, four valid low bits.
// - Programmed fuse or lock bits read zero, unprogrammed read one.
// - Timed load in signature mode returns the addressed signature byte.
// - Signature mode clears after its load or after three idle cycles.
// - With modes clear, a load is an ordinary flash read.
// - Signature identity bytes sit at pointers 0, 2 and 4.
// - Calibration at 1, sensor offset at 5, sensor gain at 7.
// - Other signature pointers are reserved and unreliable.
// - A flash write in progress finishes despite a system reset.
// - Erase, page write and lock write last 3.7 to 4.5 ms.
// - Busy read-while-write section stays unreadable until re-enabled.
// - During erase or write the busy section is not readable.
// - Boot code 11: 256 words at 0x1F00; 10: 512 at 0x1E00.
// - Code 01: 1024 at 0x1C00; 00: 2048 at 0x1800.
// - Lock-mode load returns lock bits at 1, low fuse at 0.
// - Lock mode clears without load in three or store in four; here a load in the fourth cycle leaves it set until a system reset.
// - EEPROM write blocks programming and fuse or lock reads.
`timescale 1ns/100ps
`default_nettype none
module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_MIN_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        eeprom_write_busy_bit,
  input  wire logic [7:0]  low_fuse_byte,
  input  wire logic [7:0]  high_fuse_byte,
  input  wire logic [3:0]  extended_fuse_byte,
  input  wire logic [7:0]  lock_bits,
  input  wire logic [7:0]  flash_rdata,
  output logic      [15:0] nvm_addr,
  output logic      [15:0] nvm_wdata,
  output logic             nvm_buf_load,
  output logic             nvm_buf_clear,
  output logic             nvm_erase,
  output logic             nvm_page_write,
  output logic             nvm_lock_write,
  output logic             nvm_busy,
  output logic             rw_section_busy_flag,
  output logic      [12:0] boot_start
);
  // ==================================================
  // State
  typedef struct packed {
    logic [5:0]  ctrl;
    logic        read_while_write_section;
    logic [2:0]  win;
    logic [15:0] z;
    logic [15:0] data;
    logic [7:0]  ldat;
    logic [31:0] rd;
    logic        ready;
    logic        err;
    logic        ld;
    logic        clr;
    logic        ers;
    logic        pwr;
    logic        lwr;
    logic        start;
    logic [7:0]  fl1, fl2, fh1, fh2, lk1, lk2;
    logic [3:0]  fe1, fe2;
    logic [12:0] boot;
  } fsp_st_t;

  // Timer on the power-on reset only, so a system reset cannot cut a write
  typedef struct packed {
    logic        busy;
    logic [20:0] cnt;
  } fsp_eng_t;

  fsp_st_t  s_r, s_nxt;
  fsp_eng_t e_r, e_nxt;

  logic wr, ee, armed, ld_ev, st_ev, lk_ld, sg_ld, in_rww;
  logic [7:0] ld_val;

  assign wr     = psel && penable && pwrite;
  assign ee     = eeprom_write_busy_bit;
  assign armed  = s_r.ctrl[B_OPEN];
  assign ld_ev  = wr && paddr == A_CMD && pwdata[C_LOAD];
  assign st_ev  = wr && paddr == A_CMD && pwdata[C_STORE];
  assign in_rww = s_r.z[13:1] < RWW_END;
  assign lk_ld  = armed && s_r.win < LOAD_WIN && s_r.ctrl[B_LOCK] && !ee;
  assign sg_ld  = armed && s_r.win < LOAD_WIN && s_r.ctrl[B_SIGNATURE_READ_BIT];

  // ==================================================
  // Load data selection; fuse pins already carry 0 for programmed bits
  always_comb begin
    if (lk_ld) begin
      unique case (s_r.z)
        Z_FLB:   ld_val = s_r.fl2;
        Z_LOCK:  ld_val = s_r.lk2;
        Z_EFB:   ld_val = {EFB_PAD, s_r.fe2};
        Z_FHB:   ld_val = s_r.fh2;
        default: ld_val = RD_NONE;
      endcase
    end else if (sg_ld) begin
      unique case (s_r.z)
        Z_ID1:   ld_val = SIG_ID1;
        Z_ID2:   ld_val = SIG_ID2;
        Z_ID3:   ld_val = SIG_ID3;
        Z_CAL:   ld_val = SIG_CAL;
        Z_TSOFF: ld_val = SIG_TSOFF;
        Z_TSGN:  ld_val = SIG_TSGN;
        default: ld_val = RD_NONE;
      endcase
    end else if (s_r.read_while_write_section && in_rww) begin
      ld_val = RD_NONE;
    end else begin
      ld_val = flash_rdata;
    end
  end

  // ==================================================
  // Main next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.ld    = 1'b0;
    s_nxt.clr   = 1'b0;
    s_nxt.ers   = 1'b0;
    s_nxt.pwr   = 1'b0;
    s_nxt.lwr   = 1'b0;
    s_nxt.start = 1'b0;
    s_nxt.ready = 1'b1;
    s_nxt.fl1 = low_fuse_byte;
    s_nxt.fl2 = s_r.fl1;
    s_nxt.fh1 = high_fuse_byte;
    s_nxt.fh2 = s_r.fh1;
    s_nxt.fe1 = extended_fuse_byte;
    s_nxt.fe2 = s_r.fe1;
    s_nxt.lk1 = lock_bits;
    s_nxt.lk2 = s_r.lk1;
    unique case ({s_r.fh2[BSZ_HI], s_r.fh2[BSZ_LO]})
      2'b11: s_nxt.boot = BOOT_11;
      2'b10: s_nxt.boot = BOOT_10;
      2'b01: s_nxt.boot = BOOT_01;
      2'b00: s_nxt.boot = BOOT_00;
    endcase
    if (armed && s_r.win != STORE_WIN) begin
      s_nxt.win = s_r.win + 3'h1;
    end
    if (ld_ev) begin
      s_nxt.ldat = ld_val;
      if (lk_ld || sg_ld) begin
        s_nxt.ctrl = CTRL_RST;
      end
    end else if (st_ev && armed && s_r.win < STORE_WIN && !s_r.ctrl[B_SIGNATURE_READ_BIT] && !ee) begin
      s_nxt.ctrl = CTRL_RST;
      if (s_r.ctrl[B_PAGE_ERASE_BIT]) begin
        s_nxt.ers   = 1'b1;
        s_nxt.start = 1'b1;
        s_nxt.read_while_write_section   = s_r.read_while_write_section || in_rww;
      end else if (s_r.ctrl[B_PAGE_WRITE_BIT]) begin
        s_nxt.pwr   = 1'b1;
        s_nxt.clr   = 1'b1;
        s_nxt.start = 1'b1;
        s_nxt.read_while_write_section   = s_r.read_while_write_section || in_rww;
      end else if (s_r.ctrl[B_LOCK]) begin
        s_nxt.lwr   = 1'b1;
        s_nxt.start = 1'b1;
      end else if (s_r.ctrl[B_REEN]) begin
        s_nxt.read_while_write_section = 1'b0;
        s_nxt.clr = 1'b1;
      end else begin
        s_nxt.ld = 1'b1;
      end
    end else if (armed && s_r.win == (s_r.ctrl[B_SIGNATURE_READ_BIT] ? LOAD_WIN : STORE_WIN) - 3'h1) begin
      s_nxt.ctrl = CTRL_RST;
    end
    // Refused while busy or EEPROM is writing; software polls for this
    if (wr && paddr == A_CTRL && !armed && !e_r.busy && !ee && pwdata[B_OPEN]) begin
      s_nxt.ctrl = pwdata[5:0];
      s_nxt.win  = 3'h0;
    end
    if (wr && paddr == A_ZPTR) begin
      s_nxt.z = pwdata[15:0];
    end
    if (wr && paddr == A_DATA) begin
      s_nxt.data = pwdata[15:0];
    end
    // Read data and error are decided in the setup phase
    if (psel && !penable) begin
      s_nxt.err = 1'b0;
      unique case (paddr)
        // Start pulse covers the cycle before the timer raises busy
        A_CTRL:  s_nxt.rd = {25'h0, s_r.read_while_write_section, s_r.ctrl[5:1], s_r.ctrl[B_OPEN] || s_r.start || e_r.busy};
        A_ZPTR:  s_nxt.rd = {16'h0, s_r.z};
        A_DATA:  s_nxt.rd = {16'h0, s_r.data};
        A_CMD:   s_nxt.rd = 32'h0;
        A_LDAT:  s_nxt.rd = {24'h0, s_r.ldat};
        A_BOOT:  s_nxt.rd = {19'h0, s_r.boot};
        default: begin
          s_nxt.rd  = 32'h0;
          s_nxt.err = 1'b1;
        end
      endcase
    end
  end

  // ==================================================
  // Programming timer
  always_comb begin
    e_nxt = e_r;
    if (s_r.start && !e_r.busy) begin
      e_nxt.busy = 1'b1;
      e_nxt.cnt  = 21'(PROG_CYCLES - 1);
    end else if (e_r.busy) begin
      if (e_r.cnt == 21'h0) begin
        e_nxt.busy = 1'b0;
      end else begin
        e_nxt.cnt = e_r.cnt - 21'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      e_r <= '0;
    end else begin
      e_r <= e_nxt;
    end
  end

  assign prdata               = s_r.rd;
  assign pready               = s_r.ready;
  assign pslverr              = s_r.err;
  assign nvm_addr             = s_r.z;
  assign nvm_wdata            = s_r.data;
  assign nvm_buf_load         = s_r.ld;
  assign nvm_buf_clear        = s_r.clr;
  assign nvm_erase            = s_r.ers;
  assign nvm_page_write       = s_r.pwr;
  assign nvm_lock_write       = s_r.lwr;
  assign nvm_busy             = e_r.busy;
  assign rw_section_busy_flag = s_r.read_while_write_section;
  assign boot_start           = s_r.boot;

  // ==================================================
  // Checks
  sequence arm_s;
    wr && paddr == A_CTRL && !armed && !e_r.busy && !ee && pwdata[B_OPEN];
  endsequence

  sequence idle3_s;
    !(wr && paddr == A_CMD) [*3];
  endsequence

  sequence idle4_s;
    !(wr && paddr == A_CMD) [*4];
  endsequence

  a_fuse_high_read: assert property (@(posedge pclk) disable iff (!presetn)
    ld_ev && lk_ld && s_r.z == Z_FHB |=> s_r.ldat == $past(s_r.fh2))
    else $error("high fuse read wrong");
  a_ext_fuse_pad: assert property (@(posedge pclk) disable iff (!presetn)
    ld_ev && lk_ld && s_r.z == Z_EFB |=> s_r.ldat[7:4] == EFB_PAD && s_r.ldat[3:0] == $past(s_r.fe2))
    else $error("extended fuse read wrong");
  a_sig_cal_read: assert property (@(posedge pclk) disable iff (!presetn)
    ld_ev && sg_ld && s_r.z == Z_CAL |=> s_r.ldat == SIG_CAL && s_r.ctrl == CTRL_RST)
    else $error("calibration read wrong");
  a_sig_auto_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (arm_s and pwdata[B_SIGNATURE_READ_BIT]) ##1 idle3_s |=> !armed)
    else $error("signature mode not cleared");
  a_lock_auto_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (arm_s and pwdata[B_LOCK]) ##1 idle4_s |=> !armed)
    else $error("lock mode not cleared");
  a_rww_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    ld_ev && !lk_ld && !sg_ld && s_r.read_while_write_section && in_rww |=> s_r.ldat == RD_NONE)
    else $error("busy section was read");
  a_plain_read: assert property (@(posedge pclk) disable iff (!presetn)
    ld_ev && !armed && !s_r.read_while_write_section |=> s_r.ldat == $past(flash_rdata))
    else $error("ordinary read wrong");
  a_prog_held: assert property (@(posedge pclk) disable iff (!por_n)
    s_r.start && !e_r.busy |=> e_r.busy [*8])
    else $error("programming ended early");
  a_ee_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == A_CTRL && ee && !armed |=> !armed)
    else $error("control accepted during EEPROM write");
  a_boot_top: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.fh2[BSZ_HI] && s_r.fh2[BSZ_LO] |=> boot_start == BOOT_11)
    else $error("boot start wrong");
endmodule
`default_nettype wire

// ==== hw/fsp_pkg.sv ====
/*
  Package of the flash self-programming controller: register offsets,
  control bit positions, pointer codes, signature values and timing.
  Assumes a 250 MHz APB clock and a 16K program memory.
*/
`default_nettype none
package fsp_pkg;
  // ==================================================
  // Register map (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ZPTR = 8'h04;
  localparam logic [7:0] A_DATA = 8'h08;
  localparam logic [7:0] A_CMD  = 8'h0c;
  localparam logic [7:0] A_LDAT = 8'h10;
  localparam logic [7:0] A_BOOT = 8'h14;
  // ==================================================
  // Control/status bit positions
  localparam int B_OPEN  = 0;
  localparam int B_PAGE_ERASE_BIT = 1;
  localparam int B_PAGE_WRITE_BIT = 2;
  localparam int B_LOCK  = 3;
  localparam int B_REEN  = 4;
  localparam int B_SIGNATURE_READ_BIT = 5;
  localparam int C_STORE = 0;
  localparam int C_LOAD  = 1;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // ==================================================
  // Timed windows, counted in cycles after the control write
  localparam logic [2:0] LOAD_WIN  = 3'h3;
  localparam logic [2:0] STORE_WIN = 3'h4;
  // ==================================================
  // Pointer codes
  localparam logic [15:0] Z_FLB   = 16'h0000;
  localparam logic [15:0] Z_LOCK  = 16'h0001;
  localparam logic [15:0] Z_EFB   = 16'h0002;
  localparam logic [15:0] Z_FHB   = 16'h0003;
  localparam logic [15:0] Z_ID1   = 16'h0000;
  localparam logic [15:0] Z_CAL   = 16'h0001;
  localparam logic [15:0] Z_ID2   = 16'h0002;
  localparam logic [15:0] Z_ID3   = 16'h0004;
  localparam logic [15:0] Z_TSOFF = 16'h0005;
  localparam logic [15:0] Z_TSGN  = 16'h0007;
  // Signature values: arbitrary, stand-ins for the real ones
  localparam logic [7:0] SIG_ID1   = 8'h11;
  localparam logic [7:0] SIG_ID2   = 8'h22;
  localparam logic [7:0] SIG_ID3   = 8'h33;
  localparam logic [7:0] SIG_CAL   = 8'h80;
  localparam logic [7:0] SIG_TSOFF = 8'h00;
  localparam logic [7:0] SIG_TSGN  = 8'h80;
  localparam logic [7:0] RD_NONE   = 8'hff;
  localparam logic [3:0] EFB_PAD   = 4'hf;
  localparam logic [7:0] LOCK_MASK = 8'h3c;
  // ==================================================
  // Boot section layout (word addresses)
  localparam int BSZ_HI = 2;
  localparam int BSZ_LO = 1;
  localparam logic [12:0] BOOT_11 = 13'h1f00;
  localparam logic [12:0] BOOT_10 = 13'h1e00;
  localparam logic [12:0] BOOT_01 = 13'h1c00;
  localparam logic [12:0] BOOT_00 = 13'h1800;
  localparam logic [12:0] RWW_END = 13'h1800;
  // ==================================================
  // Programming time
  localparam int PROG_MIN_US = 3700;
  localparam int PROG_MAX_US = 4500;
  localparam int CLK_MHZ     = 250;
  localparam int PROG_MIN_CYC = PROG_MIN_US * CLK_MHZ;
  localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
endpackage
`default_nettype wire

// ==== testbench/fsp_flash_model.sv ====
/*
  Flash array model: read data for the controller's pointer.
  Assumes a combinational read on the controller clock.
*/
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model (
  input  wire logic [15:0] nvm_addr,
  output logic      [7:0]  flash_rdata
);
  // ==========
  // Address-dependent pattern, so a wrong pointer shows up
  assign flash_rdata = nvm_addr[7:0] ^ 8'ha5;
endmodule
`default_nettype wire

// ==== testbench/fsp_tb_top.sv ====
/*
  Testbench of the self-programming controller, APB master and checks.
  Assumes pready comes within twenty cycles of the access phase.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_self_program_fuse_read_tb_top
  import fsp_pkg::*;
;
  localparam int PROG = 20;
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, ee = 0;
  logic [7:0] paddr = 0, lfb = 8'h62, hfb = 8'hd9, lck = 8'hfc, frd;
  logic [3:0] efb = 4'h9;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, e, nvm_busy, rwf;
  logic [15:0] na;
  logic [12:0] bs;
  logic [4:0] seen = 0;
  wire [4:0] pul;
  wire [15:0] wd;
  int n_errors = 0, n_compared = 0, busy_cnt = 0;
  always #2 pclk = ~pclk;
  // Pulses last one cycle, so they are gathered into a sticky copy
  always @(negedge pclk) begin
    if (nvm_busy === 1'b1) busy_cnt++;
    seen = seen | pul;
  end
  fsp_ctrl #(.PROG_CYCLES(PROG)) dut (.pclk(pclk), .presetn(presetn), .por_n(por_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .eeprom_write_busy_bit(ee),
    .low_fuse_byte(lfb), .high_fuse_byte(hfb), .extended_fuse_byte(efb), .lock_bits(lck),
    .flash_rdata(frd), .nvm_addr(na), .nvm_wdata(wd), .nvm_buf_load(pul[0]), .nvm_buf_clear(pul[1]),
    .nvm_erase(pul[2]), .nvm_page_write(pul[3]), .nvm_lock_write(pul[4]), .nvm_busy(nvm_busy),
    .rw_section_busy_flag(rwf), .boot_start(bs));
  fsp_flash_model flash (.nvm_addr(na), .flash_rdata(frd));
  // ==========
  // Shared tasks
  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Called right after an edge; the request is left up so transfers can run back to back
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk("pready", pready, 1);
      stop_test();
    end
    r = prdata;
    e = pslverr;
  endtask
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  task automatic ld(input logic [31:0] m, input logic [15:0] z);
    apb(1, A_ZPTR, z);
    apb(0, A_CTRL, 0);
    chk("enable_idle", r[B_OPEN], 0);
    apb(1, A_CTRL, m);
    apb(1, A_CMD, 32'h2);
    apb(0, A_LDAT, 0);
  endtask
  task automatic wait_idle;
    int k;
    for (k = 0; k < 100 && nvm_busy !== 1'b0; k++) @(negedge pclk);
    if (k >= 100) begin
      chk("busy_end", nvm_busy, 0);
      stop_test();
    end
    @(posedge pclk);
  endtask
  // ==========
  // Scenarios
  task automatic t_lock;
    logic [7:0] x[4];
    x = '{lfb, lck, {4'hf, efb}, hfb};
    for (int i = 0; i < 4; i++) begin
      ld(32'h9, 16'(i));
      chk("lock_read", r[7:0], x[i]);
    end
  endtask
  task automatic t_sig;
    logic [15:0] z[6];
    logic [7:0] x[6];
    z = '{Z_ID1, Z_CAL, Z_ID2, Z_ID3, Z_TSOFF, Z_TSGN};
    x = '{SIG_ID1, SIG_CAL, SIG_ID2, SIG_ID3, SIG_TSOFF, SIG_TSGN};
    for (int i = 0; i < 6; i++) begin
      ld(32'h21, z[i]);
      chk("sig_read", r[7:0], x[i]);
      apb(0, A_CTRL, 0);
      chk("sig_clear", r[5:0], 0);
    end
  endtask
  task automatic t_timeout;
    logic [31:0] m[2];
    m = '{32'h21, 32'h9};
    apb(1, A_ZPTR, 16'h0007);
    for (int i = 0; i < 2; i++) begin
      apb(1, A_CTRL, m[i]);
      idle(4);
      apb(0, A_CTRL, 0);
      chk("mode_expire", r[5:0], 0);
    end
    apb(1, A_CMD, 32'h2);
    apb(0, A_LDAT, 0);
    chk("plain_load", r[7:0], 8'h07 ^ 8'ha5);
  endtask
  task automatic t_eeprom;
    ee <= 1'b1;
    apb(1, A_CTRL, 32'h9);
    apb(0, A_CTRL, 0);
    chk("ee_block", r[5:0], 0);
    ee <= 1'b0;
    apb(0, 8'h18, 0);
    chk("unmapped_err", e, 1);
  endtask
  task automatic t_erase;
    apb(1, A_ZPTR, 16'h0100);
    busy_cnt = 0;
    seen = 0;
    apb(1, A_CTRL, 32'h3);
    apb(1, A_CMD, 32'h1);
    idle(2);
    apb(0, A_CTRL, 0);
    chk("busy_enable", {r[6], r[B_OPEN]}, 2'b11);
    chk("erase_pulse", seen, 5'h04);
    chk("busy_flag", rwf, 1);
    apb(1, A_CMD, 32'h2);
    apb(0, A_LDAT, 0);
    chk("rww_block", r[7:0], RD_NONE);
    idle(1);
    wait_idle();
    chk("prog_time", busy_cnt, PROG);
    apb(1, A_CMD, 32'h2);
    apb(0, A_LDAT, 0);
    chk("still_blocked", r[7:0], RD_NONE);
    apb(1, A_CTRL, 32'h11);
    apb(1, A_CMD, 32'h1);
    idle(2);
    apb(0, A_CTRL, 0);
    chk("reenabled", r[6], 0);
    chk("flag_clear", rwf, 0);
    apb(1, A_CMD, 32'h2);
    apb(0, A_LDAT, 0);
    chk("rww_read", r[7:0], 8'ha5);
    idle(1);
  endtask
  task automatic t_prog;
    seen = 0;
    apb(1, A_DATA, 32'h1234);
    apb(1, A_CTRL, 32'h1);
    apb(1, A_CMD, 32'h1);
    idle(2);
    chk("buf_load", {seen, wd}, {5'h01, 16'h1234});
    seen = 0;
    apb(1, A_CTRL, 32'h5);
    apb(1, A_CMD, 32'h1);
    idle(2);
    chk("page_write", {seen, rwf}, {5'h0a, 1'b1});
    wait_idle();
    seen = 0;
    apb(1, A_CTRL, 32'h11);
    apb(1, A_CMD, 32'h1);
    idle(2);
    chk("reenable_clear", {seen, rwf}, {5'h02, 1'b0});
    seen = 0;
    busy_cnt = 0;
    apb(1, A_CTRL, 32'h9);
    apb(1, A_CMD, 32'h1);
    idle(2);
    chk("lock_write", seen, 5'h10);
    wait_idle();
    chk("lock_time", busy_cnt, PROG);
  endtask
  task automatic t_reset;
    busy_cnt = 0;
    apb(1, A_CTRL, 32'h3);
    apb(1, A_CMD, 32'h1);
    apb(0, A_CTRL, 0);
    chk("enable_early", r[B_OPEN], 1);
    idle(3);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("busy_reset", nvm_busy, 1);
    wait_idle();
    chk("busy_full", busy_cnt, PROG);
  endtask
  task automatic t_boot;
    logic [12:0] x[4];
    x = '{BOOT_00, BOOT_01, BOOT_10, BOOT_11};
    for (int i = 0; i < 4; i++) begin
      hfb <= {5'h1b, 2'(i), 1'b1};
      idle(5);
      apb(0, A_BOOT, 0);
      chk("boot_reg", r[12:0], x[i]);
      chk("boot_pin", bs, x[i]);
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    idle(3);
    t_lock();
    t_sig();
    t_timeout();
    t_eeprom();
    t_erase();
    t_prog();
    t_reset();
    t_boot();
    stop_test();
  end
endmodule
`default_nettype wire
